/* src/motion_detect.sv */
// Freefall/motion debounce and vector-magnitude change detector with register port
//
// Contract
// - Motion flag set when counter reaches limit
// - Motion counter saturates at programmed limit
// - Time step follows rate and power mode
// - Hybrid mode halves rate, doubles step
// - Clear mode selects lapse behaviour
// - Mode 1 clears, mode 0 decrements
// - Magnitude event when difference exceeds threshold long
// - Magnitude threshold is 13-bit unsigned
// - Magnitude debounce counts samples, hybrid halved
// - References never readable by host
// - Detector runs only when enabled
// - Init source 0 captures current output
// - Init source 1 loads preset registers
// - Hold mode 0 reloads references on trigger
// - Hold mode 1 keeps enable-time references
// - Both set: preset writes update live
// - Latch off: flag follows debounced condition
// - Latch on: held until source read
`timescale 1ns/10ps
module motion_detect
  import motion_detect_pkg::*;
(
  input  wire logic                              clk,          // 250 MHz clock
  input  wire logic                              rst_n,        // Sync reset, active low
  input  wire logic [motion_detect_pkg::ADDR_W-1:0] addr,      // Register address
  input  wire logic [motion_detect_pkg::DATA_W-1:0] wdata,     // Write data
  input  wire logic                              wr_en,        // Write strobe
  input  wire logic                              rd_en,        // Read strobe
  output logic      [motion_detect_pkg::DATA_W-1:0] rdata,     // Read data, cycle after rd_en
  input  wire logic                              base_tick,    // 1.25 ms base pulse (800 Hz)
  input  wire logic                              fm_condition, // Threshold comparator result
  input  wire logic signed [motion_detect_pkg::AXIS_W-1:0] x_out, // Current X sample
  input  wire logic signed [motion_detect_pkg::AXIS_W-1:0] y_out, // Current Y sample
  input  wire logic signed [motion_detect_pkg::AXIS_W-1:0] z_out, // Current Z sample
  output logic                                   fm_event,     // Freefall/motion flag
  output logic                                   vm_event,     // Vector-magnitude flag
  output logic                                   sample_tick   // Effective sample pulse
);
  import motion_detect_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] fm_limit_reg, vm_cfg_reg, vm_ths_msb_reg, vm_ths_lsb_reg, vm_cnt_lim_reg;
  logic [7:0] mode_cfg_reg, fm_clr_reg, rdata_reg;
  logic [AXIS_W-1:0] preset_reg [3];
  logic [AXIS_W-1:0] ref_reg [3];
  logic [7:0] step_cnt_reg, fm_cnt_reg, vm_cnt_reg;
  logic       fm_flag_reg, vm_flag_reg, vm_en_d_reg, half_reg;

  wire        vm_en     = vm_cfg_reg[VM_EN_BIT];
  wire        vm_latch  = vm_cfg_reg[VM_LATCH_BIT];
  wire        vm_init   = vm_cfg_reg[VM_INIT_BIT];
  wire        vm_hold   = vm_cfg_reg[VM_HOLD_BIT];
  wire        hybrid    = mode_cfg_reg[HYBRID_BIT];
  wire pmode_t pmode    = pmode_t'(mode_cfg_reg[PMODE_LSB +: 2]);
  wire [2:0]  odr       = mode_cfg_reg[ODR_LSB +: 3];
  wire [THS_W-1:0] vm_ths = {vm_ths_msb_reg[4:0], vm_ths_lsb_reg};
  wire        src_read  = rd_en && (addr == INT_SRC_ADDR);
  wire        preset_wr = wr_en && (addr >= VM_REFX_MSB) && (addr <= VM_REFZ_LSB);
  wire [7:0]  preset_off = addr - VM_REFX_MSB;
  wire [1:0]  preset_idx = preset_off[2:1];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fm_limit_reg   <= RESET_BYTE;
      vm_cfg_reg     <= RESET_BYTE;
      vm_ths_msb_reg <= RESET_BYTE;
      vm_ths_lsb_reg <= RESET_BYTE;
      vm_cnt_lim_reg <= RESET_BYTE;
      mode_cfg_reg   <= RESET_BYTE;
      fm_clr_reg     <= RESET_BYTE;
      for (int i = 0; i < 3; i++)
        preset_reg[i] <= '0;
    end
    else if (wr_en)
    begin
      case (addr)
        FM_LIMIT_ADDR:   fm_limit_reg   <= wdata;
        VM_CFG_ADDR:     vm_cfg_reg     <= wdata;
        VM_THS_MSB_ADDR: vm_ths_msb_reg <= wdata;
        VM_THS_LSB_ADDR: vm_ths_lsb_reg <= wdata;
        VM_CNT_ADDR:     vm_cnt_lim_reg <= wdata;
        MODE_CFG_ADDR:   mode_cfg_reg   <= wdata;
        STATUS_ADDR:     fm_clr_reg     <= wdata;
        default:
          if (preset_wr)
          begin
            if (!preset_off[0])
              preset_reg[preset_idx][AXIS_W-1:8] <= wdata[AXIS_W-9:0];
            else
              preset_reg[preset_idx][7:0] <= wdata;
          end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; references are deliberately absent from this mux
  // no reference readback
  wire [7:0] rd_mux =
    (addr == FM_LIMIT_ADDR)   ? fm_limit_reg :
    (addr == VM_CFG_ADDR)     ? vm_cfg_reg :
    (addr == VM_THS_MSB_ADDR) ? vm_ths_msb_reg :
    (addr == VM_THS_LSB_ADDR) ? vm_ths_lsb_reg :
    (addr == VM_CNT_ADDR)     ? vm_cnt_lim_reg :
    (addr == MODE_CFG_ADDR)   ? mode_cfg_reg :
    (addr == STATUS_ADDR)     ? {fm_clr_reg[FM_CLRM_BIT], 7'h00} :
    (addr == INT_SRC_ADDR)    ? ({7'h00, fm_flag_reg} << INT_FM_BIT) |
                                ({7'h00, vm_flag_reg} << INT_VM_BIT) :
    UNMAPPED_BYTE;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_reg <= RESET_BYTE;
    else
      rdata_reg <= rd_en ? rd_mux : RESET_BYTE;
  end
  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Time step in base ticks, capped per power mode
  // step selection
  wire [7:0] odr_step  = 8'h01 << odr;
  wire [7:0] step_cap  = (pmode == PM_HIRES)  ? STEP_HIRES_MAX :
                         (pmode == PM_NORMAL) ? STEP_NORMAL_MAX :
                         (pmode == PM_LOW_POWER_LOW_NOISE_MODE)   ? STEP_LOW_POWER_LOW_NOISE_MODE_MAX : STEP_LP_MAX;
  wire [7:0] raw_step  = (odr > ODR_50 && pmode != PM_HIRES) ?
                         ((odr == ODR_12P5) ? STEP_LOW_POWER_LOW_NOISE_MODE_MAX : STEP_LP_MAX) : odr_step;
  wire [7:0] step_len  = (raw_step > step_cap) ? step_cap : raw_step;
  wire       step_hit  = base_tick && (step_cnt_reg + 8'h01 >= step_len);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      step_cnt_reg <= RESET_BYTE;
      half_reg     <= 1'b0;
    end
    else if (base_tick)
    begin
      step_cnt_reg <= step_hit ? RESET_BYTE : step_cnt_reg + 8'h01;
      if (step_hit)
        half_reg <= hybrid ? ~half_reg : 1'b0;
    end
  end
  assign sample_tick = step_hit && (!hybrid || half_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Freefall/motion debounce
  wire fm_clr_mode = fm_clr_reg[FM_CLRM_BIT];
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fm_cnt_reg <= RESET_BYTE;
    else if (sample_tick)
    begin
      if (fm_condition)
        fm_cnt_reg <= (fm_cnt_reg >= fm_limit_reg) ? fm_limit_reg : fm_cnt_reg + 8'h01;
      else if (fm_clr_mode)
        fm_cnt_reg <= RESET_BYTE;
      else if (fm_cnt_reg != RESET_BYTE)
        fm_cnt_reg <= fm_cnt_reg - 8'h01;
    end
  end

  // flag on reaching limit; set beats read clear
  wire fm_hit = fm_condition && (fm_cnt_reg + 8'h01 >= {1'b0, fm_limit_reg});
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fm_flag_reg <= 1'b0;
    else if (sample_tick && fm_hit)
      fm_flag_reg <= 1'b1;
    else if (src_read)
      fm_flag_reg <= 1'b0;
  end
  assign fm_event = fm_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Vector-magnitude: compare squared distance with squared threshold
  // magnitude compare
  logic signed [AXIS_W:0] dx, dy, dz;
  assign dx = x_out - $signed(ref_reg[0]);
  assign dy = y_out - $signed(ref_reg[1]);
  assign dz = z_out - $signed(ref_reg[2]);
  // Squares are formed at full width so no product is cut at axis width
  wire signed [31:0] dx_sq = dx * dx;
  wire signed [31:0] dy_sq = dy * dy;
  wire signed [31:0] dz_sq = dz * dz;
  wire [31:0] mag_sq = dx_sq + dy_sq + dz_sq;
  wire [31:0] ths_sq = 32'(vm_ths) * 32'(vm_ths);
  wire        vm_over = mag_sq > ths_sq;
  wire        vm_clr_mode = vm_ths_msb_reg[VM_CLRM_BIT];
  wire        vm_start = vm_en && !vm_en_d_reg;
  wire        vm_trig = sample_tick && vm_en && !vm_start && vm_over &&
                        (vm_cnt_reg >= vm_cnt_lim_reg);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      vm_en_d_reg <= 1'b0;
    else
      vm_en_d_reg <= vm_en;
  end

  // Reference loading
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 3; i++)
        ref_reg[i] <= '0;
    end
    else if (vm_start)
    begin
      ref_reg[0] <= vm_init ? preset_reg[0] : x_out;
      ref_reg[1] <= vm_init ? preset_reg[1] : y_out;
      ref_reg[2] <= vm_init ? preset_reg[2] : z_out;
    end
    else if (vm_en && vm_init && vm_hold)
    begin
      for (int i = 0; i < 3; i++)
        ref_reg[i] <= preset_reg[i];
    end
    else if (vm_trig && !vm_hold)
    begin
      ref_reg[0] <= x_out;
      ref_reg[1] <= y_out;
      ref_reg[2] <= z_out;
    end
  end

  // Debounce counter, shared for set and release in real-time mode
  always_ff @(posedge clk)
  begin
    if (!rst_n || !vm_en)
      vm_cnt_reg <= RESET_BYTE;
    else if (sample_tick && !vm_start)
    begin
      if (vm_over)
        vm_cnt_reg <= (vm_cnt_reg == 8'hFF) ? vm_cnt_reg : vm_cnt_reg + 8'h01;
      else if (vm_clr_mode)
        vm_cnt_reg <= RESET_BYTE;
      else if (vm_cnt_reg != RESET_BYTE)
        vm_cnt_reg <= vm_cnt_reg - 8'h01;
    end
  end

  // flag behaviour; set beats read clear
  wire vm_release = sample_tick && !vm_over && (vm_cnt_reg <= 8'h01);
  always_ff @(posedge clk)
  begin
    if (!rst_n || !vm_en)
      vm_flag_reg <= 1'b0;
    else if (vm_trig)
      vm_flag_reg <= 1'b1;
    else if (vm_latch ? src_read : vm_release)
      vm_flag_reg <= 1'b0;
  end
  assign vm_event = vm_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  sat_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    fm_cnt_reg <= fm_limit_reg || $changed(fm_limit_reg))
    else $error("motion counter above limit");
  fm_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    sample_tick && fm_hit |=> fm_event)
    else $error("motion flag not set at limit");
  fm_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    sample_tick && !fm_condition && fm_clr_mode |=> fm_cnt_reg == 8'h00)
    else $error("motion counter not cleared");
  fm_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
    sample_tick && !fm_condition && !fm_clr_mode && fm_cnt_reg != 8'h00 && !wr_en
    |=> fm_cnt_reg == $past(fm_cnt_reg) - 8'h01)
    else $error("motion counter not decremented");
  hybrid_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    sample_tick && hybrid |=> !half_reg)
    else $error("hybrid sample not halved");
  vm_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !vm_en |=> !vm_event && vm_cnt_reg == 8'h00 || $past(vm_en) == 1'b0 && vm_en)
    else $error("disabled detector not cleared");
  vm_init_a: assert property (@(posedge clk) disable iff (!rst_n)
    vm_start && !vm_init |=> ref_reg[0] == $past(x_out))
    else $error("reference not captured at enable");
  vm_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    vm_event && vm_latch && vm_en && !src_read && $stable(vm_cfg_reg) |=> vm_event)
    else $error("latched flag dropped without read");
endmodule

/* src/motion_detect_pkg.sv */
// Package: register map, field positions, reset values and timing for the motion event block
package motion_detect_pkg;
  localparam int         ADDR_W          = 8;
  localparam int         DATA_W          = 8;
  localparam int         AXIS_W          = 14;
  localparam int         THS_W           = 13;
  // Register offsets
  localparam logic [7:0] FM_LIMIT_ADDR   = 8'h18;
  localparam logic [7:0] VM_CFG_ADDR     = 8'h5F;
  localparam logic [7:0] INT_SRC_ADDR    = 8'h0C;
  localparam logic [7:0] VM_THS_MSB_ADDR = 8'h60;
  localparam logic [7:0] VM_THS_LSB_ADDR = 8'h61;
  localparam logic [7:0] VM_CNT_ADDR     = 8'h62;
  localparam logic [7:0] VM_REFX_MSB     = 8'h63;
  localparam logic [7:0] VM_REFX_LSB     = 8'h64;
  localparam logic [7:0] VM_REFY_MSB     = 8'h65;
  localparam logic [7:0] VM_REFY_LSB     = 8'h66;
  localparam logic [7:0] VM_REFZ_MSB     = 8'h67;
  localparam logic [7:0] VM_REFZ_LSB     = 8'h68;
  localparam logic [7:0] MODE_CFG_ADDR   = 8'h70;
  localparam logic [7:0] STATUS_ADDR     = 8'h71;
  // Configuration field positions
  localparam int         VM_LATCH_BIT    = 6;
  localparam int         VM_INIT_BIT     = 5;
  localparam int         VM_HOLD_BIT     = 4;
  localparam int         VM_EN_BIT       = 3;
  localparam int         VM_CLRM_BIT     = 7;
  localparam int         FM_CLRM_BIT     = 7;
  localparam int         HYBRID_BIT      = 0;
  localparam int         PMODE_LSB       = 1;
  localparam int         ODR_LSB         = 3;
  localparam int         INT_FM_BIT      = 2;
  localparam int         INT_VM_BIT      = 1;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [7:0] UNMAPPED_BYTE   = 8'h00;
  // Power modes, ODR codes 0..7 = 800,400,200,100,50,12.5,6.25,6.25 Hz
  typedef enum logic [1:0] {PM_NORMAL, PM_LOW_POWER_LOW_NOISE_MODE, PM_HIRES, PM_LOWPOWER} pmode_t;
  localparam logic [2:0] ODR_800         = 3'h0;
  localparam logic [2:0] ODR_400         = 3'h1;
  localparam logic [2:0] ODR_50          = 3'h4;
  localparam logic [2:0] ODR_12P5        = 3'h5;
  localparam logic [2:0] ODR_6P25        = 3'h6;
  // Time steps in units of the 1.25 ms base sample tick
  localparam logic [7:0] STEP_HIRES_MAX  = 8'h02;
  localparam logic [7:0] STEP_NORMAL_MAX = 8'h10;
  localparam logic [7:0] STEP_LOW_POWER_LOW_NOISE_MODE_MAX   = 8'h40;
  localparam logic [7:0] STEP_LP_MAX     = 8'h80;
endpackage

/* bench/host_model.sv */
// Host model: register writes and reads on the block's plain register port
`timescale 1ns/10ps
module host_model
(
  input  wire logic       clk,   // Block clock
  output logic      [7:0] addr,  // Register address
  output logic      [7:0] wdata, // Write data
  output logic            wr_en, // Write strobe
  output logic            rd_en, // Read strobe
  input  wire logic [7:0] rdata  // Read data, cycle after rd_en
);
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    // Data stands only in this cycle
    #1 v = rdata;
  endtask
endmodule

/* bench/accel_motion_event_detect_test.sv */
// Testbench for the motion event block: registers, debounce, time step, magnitude detector
`timescale 1ns/10ps
module accel_motion_event_detect_test;
  import motion_detect_pkg::*;
  // Base tick every 4 clocks instead of 1.25 ms keeps the run short
  localparam int BP = 4;
  logic               clk, rst_n, wr_en, rd_en, base_tick, fm_condition;
  logic               fm_event, vm_event, sample_tick;
  logic [7:0]         addr, wdata, rdata, d;
  logic signed [13:0] x_out, y_out, z_out;
  logic [7:0]         mv [6];
  logic [7:0]         pre [6];
  int                 sv [6];
  int                 bad_count, compares, n, bt;

  motion_detect i_motion_detect (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .base_tick(base_tick),
    .fm_condition(fm_condition), .x_out(x_out), .y_out(y_out), .z_out(z_out),
    .fm_event(fm_event), .vm_event(vm_event), .sample_tick(sample_tick));
  host_model i_host_model (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    bt <= (bt == BP - 1) ? 0 : bt + 1;
    base_tick <= (bt == BP - 1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int k);
    int lim;
    lim = 0;
    repeat (k)
    begin
      do
      begin
        @(negedge clk);
        lim++;
      end
      while (sample_tick !== 1'b1 && lim < 5000);
    end
    if (lim >= 5000)
    begin
      bad_count++;
      conclude();
    end
  endtask
  // Counts sample pulses until the chosen flag rises
  task automatic until_ev(input bit sel, output int t);
    t = 0;
    do
    begin
      ticks(1);
      @(negedge clk);
      t++;
    end
    while ((sel ? vm_event : fm_event) !== 1'b1 && t < 200);
    if ((sel ? vm_event : fm_event) !== 1'b1)
    begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic cond(input logic v);
    @(posedge clk);
    fm_condition <= v;
  endtask
  task automatic put_xyz(input int a, input int b, input int c);
    @(posedge clk);
    x_out <= 14'(a);
    y_out <= 14'(b);
    z_out <= 14'(c);
  endtask
  // Mode byte: odr in [5:3], power in [2:1], hybrid in [0]
  task automatic step(input logic [7:0] mode, input int exp);
    int c;
    i_host_model.wr(MODE_CFG_ADDR, mode);
    ticks(2);
    c = 0;
    do
    begin
      @(negedge clk);
      c++;
    end
    while (sample_tick !== 1'b1 && c < 2000);
    chk(16'(c), 16'(exp * BP));
  endtask
  task automatic presets(input bit zero);
    for (int i = 0; i < 6; i++)
      i_host_model.wr(VM_REFX_MSB + 8'(i), zero ? 8'h00 : pre[i]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    base_tick = 1'b0;
    fm_condition = 1'b0;
    x_out = 14'h0000;
    y_out = 14'h0000;
    z_out = 14'h0000;
    bt = 0;
    bad_count = 0;
    compares = 0;
    mv = '{8'h00, 8'h24, 8'h30, 8'h36, 8'h2A, 8'h19};
    sv = '{1, 2, 16, 128, 64, 16};
    pre = '{8'h00, 8'h3C, 8'h00, 8'h3C, 8'h3F, 8'hC4};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    i_host_model.rd(FM_LIMIT_ADDR, d);
    chk(16'(d), 16'h0000);
    i_host_model.rd(VM_CFG_ADDR, d);
    chk(16'(d), 16'h0000);
    i_host_model.rd(8'h20, d);
    chk(16'(d), 16'h0000);
    i_host_model.wr(FM_LIMIT_ADDR, 8'h03);
    i_host_model.rd(FM_LIMIT_ADDR, d);
    chk(16'(d), 16'h0003);
    i_host_model.wr(MODE_CFG_ADDR, 8'h00);
    i_host_model.wr(STATUS_ADDR, 8'h80);
    cond(1'b1);
    until_ev(1'b0, n);
    chk(16'(n), 16'h0003);
    for (int m = 0; m < 2; m++)
    begin
      i_host_model.wr(STATUS_ADDR, m ? 8'h00 : 8'h80);
      ticks(10);
      cond(1'b0);
      ticks(2);
      i_host_model.rd(INT_SRC_ADDR, d);
      chk(16'(d[INT_FM_BIT]), 16'h0001);
      @(negedge clk);
      chk(16'(fm_event), 16'h0000);
      cond(1'b1);
      until_ev(1'b0, n);
      chk(16'(n), m ? 16'h0002 : 16'h0003);
    end
    for (int k = 0; k < 6; k++)
      step(mv[k], sv[k]);
    i_host_model.wr(MODE_CFG_ADDR, 8'h08);
    i_host_model.wr(VM_THS_MSB_ADDR, 8'h00);
    i_host_model.wr(VM_THS_LSB_ADDR, 8'h64);
    i_host_model.wr(VM_CNT_ADDR, 8'h02);
    i_host_model.wr(VM_CFG_ADDR, 8'h08);
    put_xyz(57, 57, -57);
    ticks(8);
    chk(16'(vm_event), 16'h0000);
    put_xyz(60, 60, -60);
    until_ev(1'b1, n);
    chk(16'(n > 1 && n < 5), 16'h0001);
    ticks(6);
    chk(16'(vm_event), 16'h0000);
    i_host_model.rd(VM_REFX_LSB, d);
    chk(16'(d), 16'h0000);
    put_xyz(0, 0, 0);
    i_host_model.wr(VM_CFG_ADDR, 8'h00);
    i_host_model.wr(VM_CFG_ADDR, 8'h18);
    put_xyz(60, 60, -60);
    until_ev(1'b1, n);
    ticks(6);
    chk(16'(vm_event), 16'h0001);
    i_host_model.wr(VM_CFG_ADDR, 8'h00);
    repeat (2) @(negedge clk);
    chk(16'(vm_event), 16'h0000);
    put_xyz(0, 0, 0);
    i_host_model.wr(VM_CFG_ADDR, 8'h58);
    put_xyz(60, 60, -60);
    until_ev(1'b1, n);
    put_xyz(0, 0, 0);
    ticks(6);
    chk(16'(vm_event), 16'h0001);
    i_host_model.rd(INT_SRC_ADDR, d);
    chk(16'(d[INT_VM_BIT]), 16'h0001);
    @(negedge clk);
    chk(16'(vm_event), 16'h0000);
    i_host_model.wr(VM_CFG_ADDR, 8'h00);
    presets(1'b0);
    i_host_model.wr(VM_CFG_ADDR, 8'h38);
    until_ev(1'b1, n);
    chk(16'(n > 1 && n < 5), 16'h0001);
    presets(1'b1);
    ticks(6);
    chk(16'(vm_event), 16'h0000);
    conclude();
  end
endmodule
